// ### hdl/dbgrt_ppb_rom.sv
// Notes on behaviour
// - peripheral region decoded, accesses kept strictly ordered
// - register data always little-endian, never swapped
// - reserved bits read defined, writes preserve zero
// - unprivileged region access answers with bus fault
// - config bit lets unprivileged trigger writes through
// - entry upper twenty bits hold signed offset
// - valid entries read format bit one
// - present bit marks valid; others skipped
// - offsets negative; zero word ends directory
// - first entry fixed, points to control space
// - second entry watch unit, present if fitted
// - third entry patch unit, present if fitted
// - fourth entry trace unit, present if fitted
// - trace unit range never raises missing fault
// - fifth entry trace port, present if reachable
// - sixth entry macrocell, present if reachable
// - seventh entry is null terminator
// - offsets f00 to fc8 never hold entries
// - memory type word reads bit zero set
// - identification words five to seven read zero
// - component identification words fixed preamble values
`timescale 1ns/1ps
module dbgrt_ppb_rom
  import dbgrt_pkg::*;
#(
  parameter logic FIT_WATCH = 1'b1,
  parameter logic FIT_PATCH = 1'b1,
  parameter logic FIT_ITM = 1'b1,
  parameter logic FIT_TPORT = 1'b1,
  parameter logic FIT_MACRO = 1'b1,
  parameter logic [31:0] PERIPH_IDENT_0 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_1 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_2 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_3 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_4 = 32'h0000_0000,
  // arbitrary preamble values
  parameter logic [31:0] COMPONENT_IDENT_0 = 32'h0000_0011,
  parameter logic [31:0] COMPONENT_IDENT_1 = 32'h0000_0022,
  parameter logic [31:0] COMPONENT_IDENT_2 = 32'h0000_0033,
  parameter logic [31:0] COMPONENT_IDENT_3 = 32'h0000_0044
)(
  input wire logic clk,
  input wire logic rstn,
  input wire logic reqValid,
  input wire logic [31:0] reqAddr,
  input wire logic reqWrite,
  input wire logic [1:0] reqSize,
  input wire logic reqPriv,
  input wire logic [31:0] reqWdata,
  output logic rspValid,
  output logic [31:0] rspData,
  output logic rspFault,
  output logic unprivTrigEn,
  output logic trigPulse,
  output logic [TRIG_ID_W-1:0] trigId
);
  // address window test, shared by the region, directory and trace unit decoders
  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
    return (a >= lo) && (a < hi);
  endfunction

  logic [1:0] rstPipe;
  logic rstnInt;
  logic inPpb;
  logic romHit;
  logic itmHit;
  logic cfgHit;
  logic trigHit;
  logic wordXfer;
  logic unprivOk;
  logic denied;
  logic [11:0] romOfs;
  logic [31:0] readWord;
  logic [31:0] cfgWord;
  logic trigAccept;
  logic cfgWrite;

  dbgrt_rom_if romBus ();

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstnInt = rstPipe[1];

  // directory contents
  dbgrt_rom_lookup #(
    .FIT_WATCH(FIT_WATCH),
    .FIT_PATCH(FIT_PATCH),
    .FIT_ITM(FIT_ITM),
    .FIT_TPORT(FIT_TPORT),
    .FIT_MACRO(FIT_MACRO),
    .PERIPH_IDENT_0(PERIPH_IDENT_0),
    .PERIPH_IDENT_1(PERIPH_IDENT_1),
    .PERIPH_IDENT_2(PERIPH_IDENT_2),
    .PERIPH_IDENT_3(PERIPH_IDENT_3),
    .PERIPH_IDENT_4(PERIPH_IDENT_4),
    .COMPONENT_IDENT_0(COMPONENT_IDENT_0),
    .COMPONENT_IDENT_1(COMPONENT_IDENT_1),
    .COMPONENT_IDENT_2(COMPONENT_IDENT_2),
    .COMPONENT_IDENT_3(COMPONENT_IDENT_3)
  ) u_lookup (
    .rom(romBus)
  );

  // address decode
  assign inPpb = inRange(reqAddr, PPB_BASE, PPB_LIMIT);
  assign romHit = inRange(reqAddr, ROM_BASE, ROM_BASE + ROM_SIZE);
  assign itmHit = inRange(reqAddr, ITM_BASE, ITM_LIMIT);
  assign cfgHit = (reqAddr == CFG_ADDR);
  assign trigHit = (reqAddr == TRIG_ADDR);
  assign romOfs = reqAddr[OFFSET_LSB-1:0];
  assign romBus.byteOfs = romOfs;
  // narrower transfers are not acted on for writes
  assign wordXfer = (reqSize == SIZE_WORD);

  // privilege check with its two documented exceptions
  assign unprivOk = itmHit
                    || (trigHit && reqWrite && unprivTrigEn);
  assign denied = !reqPriv && !unprivOk;

  // read mux; unmapped words in the region read zero
  always_comb
  begin
    cfgWord = ZERO_WORD;
    cfgWord[CFG_UNPRIV_TRIG_BIT] = unprivTrigEn;
    if (romHit)
      readWord = romBus.word;
    else if (cfgHit)
      readWord = cfgWord;
    else
      readWord = ZERO_WORD;
  end

  // write qualifiers
  assign cfgWrite = reqValid && inPpb && reqWrite && cfgHit && wordXfer && !denied;
  assign trigAccept = reqValid && inPpb && reqWrite && trigHit && wordXfer && !denied;

  // one answer per region request, next cycle, in issue order
  always_ff @(posedge clk or negedge rstnInt)
  begin
    if (!rstnInt)
      rspValid <= 1'b0;
    else
      rspValid <= reqValid && inPpb;
  end

  // fault status of the answer
  always_ff @(posedge clk or negedge rstnInt)
  begin
    if (!rstnInt)
      rspFault <= 1'b0;
    else
      rspFault <= reqValid && inPpb && denied;
  end

  // read data, lanes passed straight through
  always_ff @(posedge clk or negedge rstnInt)
  begin
    if (!rstnInt)
      rspData <= ZERO_WORD;
    else if (reqValid && inPpb && !reqWrite && !denied)
      rspData <= readWord;
    else
      rspData <= ZERO_WORD;
  end

  // configuration bit, only the defined bit is stored
  always_ff @(posedge clk or negedge rstnInt)
  begin
    if (!rstnInt)
      unprivTrigEn <= 1'b0;
    else if (cfgWrite)
      unprivTrigEn <= reqWdata[CFG_UNPRIV_TRIG_BIT];
  end

  // software trigger pulse with its number
  always_ff @(posedge clk or negedge rstnInt)
  begin
    if (!rstnInt)
    begin
      trigPulse <= 1'b0;
      trigId <= '0;
    end
    else
    begin
      trigPulse <= trigAccept;
      if (trigAccept)
        trigId <= reqWdata[TRIG_ID_W-1:0];
    end
  end

  // checks on the answers
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstnInt);

  a_region_answer: assert property (
    reqValid && inPpb |=> rspValid)
    else $error("region access not answered");

  a_outside_quiet: assert property (
    !(reqValid && inPpb) |=> !rspValid && !rspFault)
    else $error("answer without region access");

  a_unpriv_fault: assert property (
    reqValid && inPpb && !reqPriv && romHit |=> rspFault && rspData == ZERO_WORD)
    else $error("unprivileged directory read not faulted");

  a_priv_no_fault: assert property (
    reqValid && inPpb && reqPriv |=> rspValid && !rspFault)
    else $error("privileged access faulted");

  a_trace_no_fault: assert property (
    reqValid && itmHit |=> rspValid && !rspFault)
    else $error("trace unit range faulted");

  a_trig_open: assert property (
    reqValid && reqWrite && !reqPriv && trigHit && wordXfer && unprivTrigEn
    |=> trigPulse && !rspFault && trigId == $past(reqWdata[TRIG_ID_W-1:0]))
    else $error("enabled unprivileged trigger refused");

  a_trig_locked: assert property (
    reqValid && reqWrite && !reqPriv && trigHit && !unprivTrigEn
    |=> rspFault && !trigPulse)
    else $error("locked unprivileged trigger accepted");

  a_cfg_steers: assert property (
    cfgWrite ##1 reqValid && reqWrite && !reqPriv && trigHit && wordXfer
    |=> trigPulse == $past(unprivTrigEn, 1) && rspFault == !$past(unprivTrigEn, 1))
    else $error("config bit does not steer trigger access");

  a_first_entry: assert property (
    reqValid && reqPriv && !reqWrite && reqAddr == ROM_BASE
    |=> rspData == PTR_SCS)
    else $error("first directory entry wrong");

  a_entry_format: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs <= OFS_MACRO
    |=> rspData[FORMAT_BIT] && rspData[31] && rspData[11:2] == '0)
    else $error("directory entry format wrong");

  a_entry_offset: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_WATCH
    |=> ROM_BASE + (rspData & OFFSET_MASK) == WATCH_BASE)
    else $error("watch entry offset wrong");

  a_present_flags: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_PATCH
    |=> rspData[PRESENT_BIT] == FIT_PATCH && rspData[31:FORMAT_BIT] != '0)
    else $error("patch entry present bit wrong");

  a_terminator: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_END
    |=> rspValid && rspData == TERM_VAL)
    else $error("terminator not zero");

  a_reserved_zero: assert property (
    reqValid && reqPriv && !reqWrite && romHit
    && romOfs >= OFS_RESV_LO && romOfs <= OFS_RESV_HI
    |=> rspData == ZERO_WORD)
    else $error("reserved directory word not zero");

  a_memory_type_word_bit: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_MEMORY_TYPE_WORD
    |=> rspData[0])
    else $error("memory type bit clear");

  a_ident_zero: assert property (
    reqValid && reqPriv && !reqWrite && romHit
    && romOfs >= OFS_PERIPH_IDENT_5 && romOfs <= OFS_PERIPH_IDENT_7
    |=> rspData == ZERO_WORD)
    else $error("upper identification word not zero");

  a_cid_lowbyte: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs >= OFS_COMPONENT_IDENT_0
    |=> rspData[31:8] == '0)
    else $error("preamble word uses upper bytes");

  a_rom_readonly: assert property (
    reqValid && reqWrite && romHit ##1 reqValid && reqPriv && !reqWrite
    && reqAddr == ROM_BASE |=> rspData == PTR_SCS)
    else $error("directory changed by a write");

  // answer flags only ever travel with an answer
  a_fault_answered: assert property (
    rspFault |-> rspValid)
    else $error("fault flag without answer");

  a_trig_answered: assert property (
    trigPulse |-> rspValid && !rspFault)
    else $error("trigger pulse without clean answer");

  a_write_no_data: assert property (
    reqValid && inPpb && reqWrite |=> rspData == ZERO_WORD)
    else $error("write answered with data");

  a_short_write: assert property (
    reqValid && reqWrite && !wordXfer |=> !trigPulse && $stable(unprivTrigEn))
    else $error("narrow write acted on");

  a_cfg_holds: assert property (
    !cfgWrite |=> $stable(unprivTrigEn))
    else $error("config bit changed without a write");

  a_cfg_readback: assert property (
    reqValid && reqPriv && !reqWrite && cfgHit
    |=> rspData == 32'(unprivTrigEn) << CFG_UNPRIV_TRIG_BIT)
    else $error("config word reads back wrong");

  a_trace_reads_zero: assert property (
    reqValid && itmHit && !reqWrite |=> rspData == ZERO_WORD)
    else $error("trace unit range read not zero");

  a_trace_entry: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_ITM
    |=> rspData[PRESENT_BIT] == FIT_ITM && ROM_BASE + (rspData & OFFSET_MASK) == ITM_BASE)
    else $error("trace unit entry wrong");

  a_port_entry: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_TPORT
    |=> rspData[PRESENT_BIT] == FIT_TPORT
    && rspData[31:FORMAT_BIT] == PTR_TPORT[31:FORMAT_BIT])
    else $error("trace port entry wrong");

  a_macro_entry: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs == OFS_MACRO
    |=> rspData[PRESENT_BIT] == FIT_MACRO
    && rspData[31:FORMAT_BIT] == PTR_MACRO[31:FORMAT_BIT])
    else $error("macrocell entry wrong");

  a_extension_zero: assert property (
    reqValid && reqPriv && !reqWrite && romHit && romOfs > OFS_END && romOfs < OFS_RESV_LO
    |=> rspData == ZERO_WORD)
    else $error("unused directory word not zero");
endmodule // dbgrt_ppb_rom

// ### hdl/dbgrt_pkg.sv
package dbgrt_pkg;
  // private peripheral bus window
  localparam logic [31:0] PPB_BASE = 32'he000_0000;
  localparam logic [31:0] PPB_LIMIT = 32'he010_0000;
  // unit base addresses
  localparam logic [31:0] SCS_BASE = 32'he000_e000;
  localparam logic [31:0] WATCH_BASE = 32'he000_1000;
  localparam logic [31:0] PATCH_BASE = 32'he000_2000;
  localparam logic [31:0] ITM_BASE = 32'he000_0000;
  localparam logic [31:0] ITM_LIMIT = WATCH_BASE;
  // directory entry layout
  localparam int PRESENT_BIT = 0;
  localparam int FORMAT_BIT = 1;
  localparam int OFFSET_LSB = 12;
  localparam logic [31:0] OFFSET_MASK = 32'hffff_f000;
  localparam logic [31:0] FMT_ONLY = 32'h0000_0002;
  // pointer entries with present bit set, then fixed words
  localparam logic [31:0] PTR_SCS = 32'hfff0_f003;
  localparam logic [31:0] PTR_WATCH = 32'hfff0_2003;
  localparam logic [31:0] PTR_PATCH = 32'hfff0_3003;
  localparam logic [31:0] PTR_ITM = 32'hfff0_1003;
  localparam logic [31:0] PTR_TPORT = 32'hfff4_1003;
  localparam logic [31:0] PTR_MACRO = 32'hfff4_2003;
  localparam logic [31:0] TERM_VAL = 32'h0000_0000;
  localparam logic [31:0] MEMORY_TYPE_WORD_VAL = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  // directory base follows from the first pointer
  localparam logic [31:0] ROM_BASE = SCS_BASE - (PTR_SCS & OFFSET_MASK);
  localparam logic [31:0] ROM_SIZE = 32'h0000_1000;
  // byte offsets inside the directory
  localparam logic [11:0] OFS_SCS = 12'h000;
  localparam logic [11:0] OFS_WATCH = 12'h004;
  localparam logic [11:0] OFS_PATCH = 12'h008;
  localparam logic [11:0] OFS_ITM = 12'h00c;
  localparam logic [11:0] OFS_TPORT = 12'h010;
  localparam logic [11:0] OFS_MACRO = 12'h014;
  localparam logic [11:0] OFS_END = 12'h018;
  localparam logic [11:0] OFS_RESV_LO = 12'hf00;
  localparam logic [11:0] OFS_RESV_HI = 12'hfc8;
  localparam logic [11:0] OFS_MEMORY_TYPE_WORD = 12'hfcc;
  localparam logic [11:0] OFS_PERIPH_IDENT_4 = 12'hfd0;
  localparam logic [11:0] OFS_PERIPH_IDENT_5 = 12'hfd4;
  localparam logic [11:0] OFS_PERIPH_IDENT_6 = 12'hfd8;
  localparam logic [11:0] OFS_PERIPH_IDENT_7 = 12'hfdc;
  localparam logic [11:0] OFS_PERIPH_IDENT_0 = 12'hfe0;
  localparam logic [11:0] OFS_PERIPH_IDENT_1 = 12'hfe4;
  localparam logic [11:0] OFS_PERIPH_IDENT_2 = 12'hfe8;
  localparam logic [11:0] OFS_PERIPH_IDENT_3 = 12'hfec;
  localparam logic [11:0] OFS_COMPONENT_IDENT_0 = 12'hff0;
  localparam logic [11:0] OFS_COMPONENT_IDENT_1 = 12'hff4;
  localparam logic [11:0] OFS_COMPONENT_IDENT_2 = 12'hff8;
  localparam logic [11:0] OFS_COMPONENT_IDENT_3 = 12'hffc;
  // configuration and software trigger words
  localparam logic [31:0] CFG_ADDR = 32'he000_ed00;
  localparam logic [31:0] TRIG_ADDR = 32'he000_ef00;
  localparam int CFG_UNPRIV_TRIG_BIT = 1;
  localparam int TRIG_ID_W = 9;
  // transfer size code for a word
  localparam logic [1:0] SIZE_WORD = 2'h2;
endpackage

// ### hdl/dbgrt_rom_if.sv
`timescale 1ns/1ps
interface dbgrt_rom_if;
  logic [11:0] byteOfs;
  logic [31:0] word;
  modport lookup (input byteOfs, output word);
  modport user (output byteOfs, input word);
endinterface

// ### hdl/dbgrt_rom_lookup.sv
`timescale 1ns/1ps
module dbgrt_rom_lookup
  import dbgrt_pkg::*;
#(
  parameter logic FIT_WATCH = 1'b1,
  parameter logic FIT_PATCH = 1'b1,
  parameter logic FIT_ITM = 1'b1,
  parameter logic FIT_TPORT = 1'b1,
  parameter logic FIT_MACRO = 1'b1,
  parameter logic [31:0] PERIPH_IDENT_0 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_1 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_2 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_3 = 32'h0000_0000,
  parameter logic [31:0] PERIPH_IDENT_4 = 32'h0000_0000,
  // arbitrary preamble values
  parameter logic [31:0] COMPONENT_IDENT_0 = 32'h0000_0011,
  parameter logic [31:0] COMPONENT_IDENT_1 = 32'h0000_0022,
  parameter logic [31:0] COMPONENT_IDENT_2 = 32'h0000_0033,
  parameter logic [31:0] COMPONENT_IDENT_3 = 32'h0000_0044
)(
  dbgrt_rom_if.lookup rom
);
  // pointer with present bit from the fitted flag
  function automatic logic [31:0] ptrEntry(input logic [31:0] full, input logic fitted);
    logic [31:0] e;
    e = full;
    e[PRESENT_BIT] = fitted;
    return e;
  endfunction

  // word lookup; anything unlisted reads zero
  always_comb
  begin
    unique case (rom.byteOfs)
      OFS_SCS: rom.word = PTR_SCS;
      OFS_WATCH: rom.word = ptrEntry(PTR_WATCH, FIT_WATCH);
      OFS_PATCH: rom.word = ptrEntry(PTR_PATCH, FIT_PATCH);
      OFS_ITM: rom.word = ptrEntry(PTR_ITM, FIT_ITM);
      OFS_TPORT: rom.word = ptrEntry(PTR_TPORT, FIT_TPORT);
      OFS_MACRO: rom.word = ptrEntry(PTR_MACRO, FIT_MACRO);
      OFS_END: rom.word = TERM_VAL;
      OFS_MEMORY_TYPE_WORD: rom.word = MEMORY_TYPE_WORD_VAL;
      OFS_PERIPH_IDENT_4: rom.word = PERIPH_IDENT_4;
      OFS_PERIPH_IDENT_5, OFS_PERIPH_IDENT_6, OFS_PERIPH_IDENT_7: rom.word = ZERO_WORD;
      OFS_PERIPH_IDENT_0: rom.word = PERIPH_IDENT_0;
      OFS_PERIPH_IDENT_1: rom.word = PERIPH_IDENT_1;
      OFS_PERIPH_IDENT_2: rom.word = PERIPH_IDENT_2;
      OFS_PERIPH_IDENT_3: rom.word = PERIPH_IDENT_3;
      OFS_COMPONENT_IDENT_0: rom.word = COMPONENT_IDENT_0;
      OFS_COMPONENT_IDENT_1: rom.word = COMPONENT_IDENT_1;
      OFS_COMPONENT_IDENT_2: rom.word = COMPONENT_IDENT_2;
      OFS_COMPONENT_IDENT_3: rom.word = COMPONENT_IDENT_3;
      default: rom.word = ZERO_WORD;
    endcase
  end
endmodule // dbgrt_rom_lookup

// ### testbench/dbgrt_debugger_model.sv
`timescale 1ns/1ps
// debugger model issuing accesses through its memory access port
module dbgrt_debugger_model
  import dbgrt_pkg::*;
#(
  parameter logic [31:0] AP_BASE = 32'he00f_f000
)(
  input wire logic clk,
  output logic reqValid,
  output logic [31:0] reqAddr,
  output logic reqWrite,
  output logic [1:0] reqSize,
  output logic reqPriv,
  output logic [31:0] reqWdata
);
  // idle bus at time zero
  initial
  begin
    reqValid = 1'b0;
    reqAddr = 32'h0;
    reqWrite = 1'b0;
    reqSize = SIZE_WORD;
    reqPriv = 1'b1;
    reqWdata = 32'h0;
  end

  // one request per edge, held until the next issue or release_bus
  task automatic issue(input logic [31:0] a, input logic w, input logic p,
                       input logic [1:0] s, input logic [31:0] d);
    @(posedge clk);
    reqValid <= 1'b1;
    reqAddr <= a;
    reqWrite <= w;
    reqSize <= s;
    reqPriv <= p;
    reqWdata <= d;
  endtask

  // released address and data lines toggle so stale values never look valid
  task automatic release_bus();
    @(posedge clk);
    reqValid <= 1'b0;
    reqAddr <= ~reqAddr;
    reqWdata <= ~reqWdata;
  endtask
endmodule // dbgrt_debugger_model

// ### testbench/debug_rom_table_ppb_access_test.sv
`timescale 1ns/1ps
// self-checking bench for the directory and region access behaviour
module debug_rom_table_ppb_access_test;
  import dbgrt_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic fault;
    logic trig;
    logic en;
    logic [8:0] id;
  } dbgrt_note_t;
  // arbitrary identification values
  localparam logic [31:0] PERIPH_IDENT_4_V = 32'h0000_0004;
  localparam logic [31:0] CID_V [4] = '{32'h1a, 32'h2b, 32'h3c, 32'h4d};
  logic clk, rstn, reqValid, reqWrite, reqPriv, rspValid, rspFault, unprivTrigEn, trigPulse;
  logic [31:0] reqAddr, reqWdata, rspData;
  logic [1:0] reqSize;
  logic [8:0] trigId;
  logic en;
  dbgrt_note_t notes[$];
  dbgrt_note_t seen;
  int n_errors = 0;
  int total_checks = 0;

  dbgrt_ppb_rom #(.FIT_PATCH(1'b0), .FIT_MACRO(1'b0), .PERIPH_IDENT_4(PERIPH_IDENT_4_V), .COMPONENT_IDENT_0(CID_V[0]),
    .COMPONENT_IDENT_1(CID_V[1]), .COMPONENT_IDENT_2(CID_V[2]), .COMPONENT_IDENT_3(CID_V[3])) u_dut (.clk(clk), .rstn(rstn),
    .reqValid(reqValid), .reqAddr(reqAddr), .reqWrite(reqWrite), .reqSize(reqSize),
    .reqPriv(reqPriv), .reqWdata(reqWdata), .rspValid(rspValid), .rspData(rspData),
    .rspFault(rspFault), .unprivTrigEn(unprivTrigEn), .trigPulse(trigPulse), .trigId(trigId));

  dbgrt_debugger_model u_dbg (.clk(clk), .reqValid(reqValid), .reqAddr(reqAddr),
    .reqWrite(reqWrite), .reqSize(reqSize), .reqPriv(reqPriv), .reqWdata(reqWdata));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // expected directory contents
  function automatic logic [31:0] rom(input logic [11:0] o);
    case (o)
      OFS_SCS: return 32'hfff0_f003;
      OFS_WATCH: return 32'hfff0_2003;
      OFS_PATCH: return 32'hfff0_3002;
      OFS_ITM: return 32'hfff0_1003;
      OFS_TPORT: return 32'hfff4_1003;
      OFS_MACRO: return 32'hfff4_2002;
      OFS_MEMORY_TYPE_WORD: return 32'h0000_0001;
      OFS_PERIPH_IDENT_4: return PERIPH_IDENT_4_V;
      OFS_COMPONENT_IDENT_0: return CID_V[0];
      OFS_COMPONENT_IDENT_1: return CID_V[1];
      OFS_COMPONENT_IDENT_2: return CID_V[2];
      OFS_COMPONENT_IDENT_3: return CID_V[3];
      default: return 32'h0;
    endcase
  endfunction

  // notes the expected answer, then issues the request
  task automatic access(input logic [31:0] a, input logic w, input logic p,
                        input logic [1:0] s, input logic [31:0] d);
    dbgrt_note_t n;
    n = '0;
    if (a >= PPB_BASE && a < PPB_LIMIT)
    begin
      if (!p && a[31:12] != ITM_BASE[31:12] && !(w && a == TRIG_ADDR && en))
        n.fault = 1'b1;
      else if (w && s == SIZE_WORD && a == CFG_ADDR)
        en = d[CFG_UNPRIV_TRIG_BIT];
      else if (w && s == SIZE_WORD && a == TRIG_ADDR)
        {n.trig, n.id} = {1'b1, d[8:0]};
      else if (!w && a == CFG_ADDR)
        n.data = 32'(en) << CFG_UNPRIV_TRIG_BIT;
      else if (!w && a[31:12] == ROM_BASE[31:12])
        n.data = rom(a[11:0]);
      n.en = en;
      notes.push_back(n);
    end
    u_dbg.issue(a, w, p, s, d);
  endtask

  task automatic drain();
    int k;
    u_dbg.release_bus();
    for (k = 0; k < 8 && notes.size() > 0; k++)
      @(posedge clk);
    if (notes.size() > 0)
    begin
      check("answer count", 32'(notes.size()), 32'h0);
      tally_and_finish();
    end
  endtask

  // takes the oldest note whenever an answer shows
  always @(negedge clk)
  begin
    if (rspValid === 1'b1)
    begin
      if (notes.size() == 0)
        check("stray answer", 32'h1, 32'h0);
      else
      begin
        seen = notes.pop_front();
        check("rspData", rspData, seen.data);
        check("rspFault", 32'(rspFault), 32'(seen.fault));
        check("trigPulse", 32'(trigPulse), 32'(seen.trig));
        check("unprivTrigEn", 32'(unprivTrigEn), 32'(seen.en));
        if (seen.trig)
          check("trigId", 32'(trigId), 32'(seen.id));
      end
    end
    else
      check("trigPulse idle", 32'(trigPulse), 32'h0);
  end

  initial
  begin
    logic [11:0] o;
    rstn = 1'b0;
    en = 1'b0;
    void'($urandom(32'h394c));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    // scan from the port base up to the terminator, then sampled words up to the last identification word
    for (int i = 0; i < 7; i++)
      access(u_dbg.AP_BASE + 32'(i * 4), 1'b0, 1'b1, SIZE_WORD, 32'h0);
    for (o = 12'h020; o != 12'hf04; o = (o == 12'h020) ? 12'hefc : o + 12'h4)
      access(ROM_BASE + 32'(o), 1'b0, 1'b1, SIZE_WORD, 32'h0);
    for (o = 12'hfc8; o != 12'h000; o = o + 12'h4)
      access(ROM_BASE + 32'(o), 1'b0, 1'b1, SIZE_WORD, 32'h0);
    // writes into the directory leave it unchanged
    access(ROM_BASE, 1'b1, 1'b1, SIZE_WORD, $urandom());
    access(ROM_BASE + 32'h20, 1'b1, 1'b1, SIZE_WORD, 32'h0);
    access(ROM_BASE, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(ROM_BASE + 32'h20, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(ROM_BASE, 1'b0, 1'b0, SIZE_WORD, 32'h0);
    // random traffic into the trace unit range
    repeat (8)
      access({20'he0000, 10'($urandom()), 2'b00}, 1'($urandom()), 1'($urandom()),
             SIZE_WORD, $urandom());
    // trigger word guarded by the config bit
    access(TRIG_ADDR, 1'b1, 1'b0, SIZE_WORD, $urandom());
    access(CFG_ADDR, 1'b1, 1'b1, SIZE_WORD, 32'h2);
    access(TRIG_ADDR, 1'b1, 1'b0, SIZE_WORD, $urandom());
    access(TRIG_ADDR, 1'b1, 1'b0, 2'h0, $urandom());
    access(TRIG_ADDR, 1'b1, 1'b1, 2'h1, $urandom());
    access(TRIG_ADDR, 1'b1, 1'b1, SIZE_WORD, $urandom());
    access(CFG_ADDR, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(CFG_ADDR, 1'b1, 1'b1, SIZE_WORD, 32'h0);
    access(TRIG_ADDR, 1'b1, 1'b0, SIZE_WORD, $urandom());
    // region edges
    access(PPB_LIMIT, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(PPB_BASE - 32'h4, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(PPB_LIMIT - 32'h4, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(CFG_ADDR, 1'b1, 1'b1, SIZE_WORD, 32'h2);
    drain();
    // second reset clears the config bit
    rstn <= 1'b0;
    repeat (2) @(negedge clk);
    check("unprivTrigEn in reset", 32'(unprivTrigEn), 32'h0);
    check("trigId in reset", 32'(trigId), 32'h0);
    en = 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    access(CFG_ADDR, 1'b0, 1'b1, SIZE_WORD, 32'h0);
    access(TRIG_ADDR, 1'b1, 1'b0, SIZE_WORD, $urandom());
    drain();
    tally_and_finish();
  end
endmodule // debug_rom_table_ppb_access_test
